// [rtl/bmf_pkg.sv]
// shared constants, register map and carrier types of the converter mode and fault control
package bmf_pkg;

	// clock and timing, times in their own units
	localparam int unsigned CLK_MHZ            = 125;
	localparam int unsigned SS_TIME_US         = 9000;
	localparam int unsigned LIM_FAULT_TIME_US  = 16500;
	localparam int unsigned HICCUP_TIME_US     = 16000;
	localparam int unsigned BATT_FAULT_TIME_NS = 8000;
	localparam int unsigned SYNC_LOSS_TIME_NS  = 20000;
	localparam int unsigned SS_CYC_DEF         = SS_TIME_US * CLK_MHZ;
	localparam int unsigned LIM_CYC_DEF        = LIM_FAULT_TIME_US * CLK_MHZ;
	localparam int unsigned HICCUP_CYC_DEF     = HICCUP_TIME_US * CLK_MHZ;
	localparam int unsigned BATT_CYC           = (BATT_FAULT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SYNC_LOSS_CYC      = (SYNC_LOSS_TIME_NS * CLK_MHZ) / 1000;

	// timer and field widths
	localparam int unsigned TMR_W      = 22;
	localparam int unsigned SS_LEVEL_W = 10;
	localparam int unsigned PER_W      = 16;
	localparam int unsigned CYC_W      = 18;
	localparam int unsigned SYNC_TMR_W = 12;
	localparam logic [2:0]  PEAK_RUN_LIMIT = 3'h4;

	// dither depth 133/4096 and duty ceiling 31/32 of the period
	localparam logic [7:0]  DITHER_NUM  = 8'h85;
	localparam int unsigned DITHER_SHIFT = 12;
	localparam logic [4:0]  DUTY_NUM    = 5'h1f;
	localparam int unsigned DUTY_SHIFT  = 5;

	// register byte offsets
	localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
	localparam logic [31:0] OFS_PERIOD = 32'h0000_0004;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
	localparam logic [31:0] OFS_EVENT  = 32'h0000_000c;

	// ctrl fields and reset values
	localparam int unsigned CTRL_SKIP_ALLOW = 0;
	localparam int unsigned CTRL_SPREAD_EN  = 1;
	localparam logic [1:0]  CTRL_RESET      = 2'h1;
	localparam logic [15:0] PERIOD_RESET    = 16'h011c;

	// status fields
	localparam int unsigned ST_STATE_LSB  = 0;
	localparam int unsigned ST_FORCED     = 2;
	localparam int unsigned ST_SYNC_CLK   = 3;
	localparam int unsigned ST_DITHER     = 4;
	localparam int unsigned ST_FAULT      = 5;
	localparam int unsigned ST_DROPOUT    = 6;
	localparam int unsigned ST_BIAS       = 7;
	localparam int unsigned ST_SS_LSB     = 8;

	// event fields, write one to clear
	localparam int unsigned EV_HICCUP    = 0;
	localparam int unsigned EV_BATT      = 1;
	localparam int unsigned EV_LIM_FAULT = 2;
	localparam int unsigned EV_CONV_RST  = 3;
	localparam int unsigned EV_W         = 4;

	// ahb-lite codes
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic       HRESP_OKAY = 1'h0;

	typedef enum logic [1:0] {
		BMF_OFF    = 2'b00,
		BMF_SOFT   = 2'b01,
		BMF_RUN    = 2'b10,
		BMF_HICCUP = 2'b11
	} bmf_state_t;

	// comparator and pin levels from the analog side
	typedef struct packed {
		logic converter_enable_in;
		logic system_enable_in;
		logic main_supply_above_2v7;
		logic bias_above_uvlo;
		logic sync_level;
		logic charge_mode_sel_hi;
		logic charge_mode_sel_lo;
		logic dplus_above_vih;
		logic dminus_above_vih;
		logic dplus_below_vil;
		logic dminus_below_vil;
		logic dminus_above_float;
		logic dplus_above_ref;
		logic load_sense_above_48mv;
		logic load_sense_over_limit;
		logic peak_current_over;
		logic output_above_4v75;
		logic output_below_2v0;
		logic output_below_target;
		logic skip_peak_reached;
		logic feedback_above_reg;
		logic loop_off_req;
		logic dropout_detect;
		logic output_short_batt;
		logic output_short_gnd;
	} bmf_sense_t;

	typedef struct packed {
		logic high_side_on;
		logic low_side_on;
	} bmf_gate_t;

endpackage : bmf_pkg

// [rtl/bmf_sync.sv]
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module bmf_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// levels
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					meta    <= 1'b0;
					dout[i] <= 1'b0;
				end else begin
					meta    <= din[i];
					dout[i] <= meta;
				end
			end
		end
	endgenerate

endmodule : bmf_sync

`default_nettype wire

// [rtl/bmf_top.sv]
// converter enable, soft-start, mode selection and fault timing with an ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: converter switches only while the converter enable level is high.
// R2: internal supply enable rises once system enable is high and supply exceeds 2.7V.
// R3: system enable low drops internal supply and stops everything; the code stops switching and fault_out, mode logic and registers run on.
// R4: internal supply below lockout keeps all control logic disabled; the code holds the sequencer off and fault_out low, other logic runs.
// R5: enabling ramps the output target from zero to full over about 9ms.
// R6: an external sync clock must be 40-60% duty, within 20% and under 2.3MHz.
// R7: sync pin high or clocked forces constant-frequency operation at all loads.
// R8: sync low: load sense above 48mV forces, below allows skip.
// R9: select 0/1: any data line above vih forces; skip needs both below vil.
// R10: high select set: dminus below float, or both above, forces constant frequency.
// R11: skip: high side on until 300mA peak and feedback high, then both off.
// R12: dither period up to 3.25% only while the internal oscillator runs.
// R13: peak or load limit turns the high side off and starts limit handling.
// R14: load limit lasting beyond 16.5ms asserts the fault output.
// R15: load limit with output above 4.75V beyond 16.5ms resets the converter.
// R16: four peak cycles with output below 2.0V: high side off 16ms, restart.
// R17: dropout lets duty approach 97% and lowers the switching frequency.
// R18: output short to battery stops switching; fault follows 8us later.
// R19: short to ground or undervoltage disables for 16ms then retries soft-start.
// R20: persistence timers count only while their condition holds, else clear.
// R21: mode priority is sync first, then charge-mode detection, then load sense.
module bmf_top
	import bmf_pkg::*;
#(
	parameter int unsigned SS_CYC     = SS_CYC_DEF,
	parameter int unsigned LIM_CYC    = LIM_CYC_DEF,
	parameter int unsigned HICCUP_CYC = HICCUP_CYC_DEF
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	// analog comparator levels
	input  wire bmf_sense_t  sense_in,
	// converter controls
	output var  bmf_gate_t   gate,
	output var  logic        bias_enable,
	output var  logic        fault_out,
	output var  logic        forced_constant_freq,
	output var  logic        dither_active,
	output var  logic [9:0]  ss_level
);

	localparam int unsigned SS_STEP_RAW = SS_CYC >> SS_LEVEL_W;
	localparam logic [TMR_W-1:0] SS_STEP = TMR_W'((SS_STEP_RAW == 0) ? 1 : SS_STEP_RAW);
	localparam logic [TMR_W-1:0] LIM_MAX = TMR_W'(LIM_CYC);
	localparam logic [TMR_W-1:0] HIC_MAX = TMR_W'(HICCUP_CYC);
	localparam logic [TMR_W-1:0] BATT_MAX = TMR_W'(BATT_CYC);
	localparam logic [SYNC_TMR_W-1:0] SYNC_MAX = SYNC_TMR_W'(SYNC_LOSS_CYC);
	localparam logic [SS_LEVEL_W-1:0] SS_FULL = '1;

	bmf_sense_t s;
	bmf_state_t state;
	bmf_state_t next_state;

	// every comparator level crosses from the analog side before use
	bmf_sync #(.W($bits(bmf_sense_t))) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (sense_in),
		.dout    (s)
	);

	// supply gating
	wire next_bias   = s.system_enable_in & s.main_supply_above_2v7;       // R2 R3
	wire supply_ok   = bias_enable & s.bias_above_uvlo;                    // R4
	wire conv_enable = supply_ok & s.converter_enable_in;                  // R1

	// sync clock detection: an edge within the loss window means clocked
	logic                  sync_d;
	logic [SYNC_TMR_W-1:0] sync_tmr;
	wire sync_rise    = s.sync_level & ~sync_d;
	wire sync_clocked = (sync_tmr != '0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_d   <= 1'b0;
			sync_tmr <= '0;
		end else begin
			sync_d   <= s.sync_level;
			sync_tmr <= sync_rise ? SYNC_MAX : (sync_clocked ? sync_tmr - 1'b1 : sync_tmr);
		end
	end

	// registers
	logic [1:0]       ctrl;
	logic [PER_W-1:0] period;
	logic [EV_W-1:0]  events;

	// mode selection in priority order
	wire dcp_sel     = ~s.charge_mode_sel_hi & s.charge_mode_sel_lo;
	wire cdp_force   = s.dplus_above_vih | s.dminus_above_vih;
	wire cdp_idle    = s.dplus_below_vil & s.dminus_below_vil;
	wire hi_force    = ~s.dminus_above_float | (s.dminus_above_float & s.dplus_above_ref);
	wire sync_forces = s.sync_level | sync_clocked;
	wire next_forced = sync_forces ? 1'b1 :                                // R7 R21
		(dcp_sel & cdp_force) ? 1'b1 :                                     // R9
		(s.charge_mode_sel_hi & hi_force) ? 1'b1 :                         // R10
		s.load_sense_above_48mv ? 1'b1 :                                   // R8
		(dcp_sel & ~cdp_idle) ? 1'b1 :                                     // R9
		~ctrl[CTRL_SKIP_ALLOW];

	// switching period with dither and dropout stretch
	logic [CYC_W-1:0]  cyc_cnt;
	logic [12:0]       dither_pos;
	logic              dither_up;
	wire [23:0]        dev_prod  = period * DITHER_NUM;
	wire [11:0]        dev       = dev_prod[23:DITHER_SHIFT];
	wire [12:0]        dev2      = {dev, 1'b0};
	wire               next_dith = ctrl[CTRL_SPREAD_EN] & ~sync_clocked;   // R12
	wire [16:0]        dith_per  = {1'b0, period} - {5'h0, dev} + {4'h0, dither_pos};
	wire [16:0]        base_per  = dither_active ? dith_per : {1'b0, period};
	wire [CYC_W-1:0]   eff_per   = s.dropout_detect ? {base_per, 1'b0} : {1'b0, base_per}; // R17
	wire [22:0]        max_prod  = eff_per * DUTY_NUM;
	wire [CYC_W-1:0]   max_on    = max_prod[22:DUTY_SHIFT];                // R17
	wire internal_end = (cyc_cnt >= eff_per - 1'b1);
	wire cycle_start  = sync_clocked ? sync_rise : internal_end;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_cnt    <= '0;
			dither_pos <= '0;
			dither_up  <= 1'b1;
		end else if (cycle_start) begin
			cyc_cnt <= '0;
			if (!dither_active) begin
				dither_pos <= {1'b0, dev};
			end else if (dither_up) begin
				dither_pos <= dither_pos + 1'b1;
				dither_up  <= (dither_pos + 1'b1 < dev2);
			end else begin
				dither_pos <= (dither_pos == '0) ? dither_pos : dither_pos - 1'b1;
				dither_up  <= (dither_pos <= 13'h1);
			end
		end else begin
			cyc_cnt <= (cyc_cnt == '1) ? cyc_cnt : cyc_cnt + 1'b1;
		end
	end

	// persistence timers, each cleared the moment its condition drops
	logic [TMR_W-1:0] lim_tmr;
	logic [TMR_W-1:0] rst_tmr;
	logic [TMR_W-1:0] batt_tmr;
	wire rst_cond  = s.load_sense_over_limit & s.output_above_4v75;
	wire lim_fault = (lim_tmr >= LIM_MAX);                                 // R14
	wire conv_rst  = (rst_tmr >= LIM_MAX);                                 // R15
	wire batt_flt  = (batt_tmr >= BATT_MAX);                               // R18

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lim_tmr  <= '0;
			rst_tmr  <= '0;
			batt_tmr <= '0;
		end else begin
			lim_tmr  <= !s.load_sense_over_limit ? '0 : (lim_fault ? lim_tmr : lim_tmr + 1'b1); // R20
			rst_tmr  <= !rst_cond ? '0 : (conv_rst ? rst_tmr : rst_tmr + 1'b1);                 // R20
			batt_tmr <= !s.output_short_batt ? '0 : (batt_flt ? batt_tmr : batt_tmr + 1'b1);    // R20
		end
	end

	// consecutive peak-limited cycles
	logic       peak_seen;
	logic [2:0] peak_run;
	wire peak_hiccup = cycle_start & (peak_seen | s.peak_current_over)
		& (peak_run == PEAK_RUN_LIMIT - 1'b1) & s.output_below_2v0;      // R16

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			peak_seen <= 1'b0;
			peak_run  <= '0;
		end else if (cycle_start) begin
			peak_seen <= 1'b0;
			peak_run  <= (peak_seen | s.peak_current_over) ?
				((peak_run == PEAK_RUN_LIMIT) ? peak_run : peak_run + 1'b1) : '0;
		end else if (s.peak_current_over) begin
			peak_seen <= 1'b1;
		end
	end

	// sequencer
	logic [TMR_W-1:0] tmr;
	wire running   = (state == BMF_SOFT) | (state == BMF_RUN);
	wire hiccup_go = s.output_short_gnd | peak_hiccup;                     // R16 R19
	wire ss_step   = (tmr >= SS_STEP - 1'b1);

	always_comb begin
		next_state = state;
		case (state)
			BMF_OFF:    next_state = BMF_SOFT;                             // R5
			BMF_SOFT:   next_state = (ss_step && ss_level == SS_FULL) ? BMF_RUN : BMF_SOFT;
			BMF_RUN:    next_state = BMF_RUN;
			BMF_HICCUP: next_state = (tmr >= HIC_MAX - 1'b1) ? BMF_SOFT : BMF_HICCUP; // R19
			default:    next_state = BMF_OFF;
		endcase
		if (running && hiccup_go) begin
			next_state = BMF_HICCUP;                                       // R16 R19
		end
		if (running && conv_rst) begin
			next_state = BMF_OFF;                                          // R15
		end
		if (!conv_enable) begin
			next_state = BMF_OFF;                                          // R1 R4
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= BMF_OFF;
			tmr      <= '0;
			ss_level <= '0;
		end else begin
			state <= next_state;
			if (next_state != state) begin
				tmr <= '0;
			end else if (state == BMF_SOFT && ss_step) begin
				tmr <= '0;
			end else if (state != BMF_RUN && state != BMF_OFF) begin
				tmr <= tmr + 1'b1;
			end
			if (next_state == BMF_OFF || next_state == BMF_HICCUP) begin
				ss_level <= '0;
			end else if (state == BMF_SOFT && ss_step && ss_level != SS_FULL) begin
				ss_level <= ss_level + 1'b1;                               // R5
			end
		end
	end

	// gate drive
	wire sw_allow = running & (next_state == state) & ~s.output_short_batt; // R18
	wire hs_limit = s.peak_current_over | s.load_sense_over_limit;          // R13
	wire hs_forced_constant_freq_off = s.loop_off_req | (cyc_cnt >= max_on);
	wire hs_skip_off = s.skip_peak_reached & s.feedback_above_reg;          // R11
	logic next_hs;

	always_comb begin
		next_hs = gate.high_side_on;
		if (forced_constant_freq) begin
			if (cycle_start) begin
				next_hs = 1'b1;
			end else if (hs_forced_constant_freq_off) begin
				next_hs = 1'b0;
			end
		end else begin
			if (hs_skip_off) begin
				next_hs = 1'b0;                                            // R11
			end else if (s.output_below_target) begin
				next_hs = 1'b1;                                            // R11
			end
		end
		if (!sw_allow || hs_limit) begin
			next_hs = 1'b0;                                                // R13
		end
	end

	// low side only fills the off time in constant-frequency operation
	wire next_ls = sw_allow & forced_constant_freq & ~next_hs;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate                 <= '0;
			bias_enable          <= 1'b0;
			fault_out            <= 1'b0;
			forced_constant_freq <= 1'b1;
			dither_active        <= 1'b0;
		end else begin
			gate.high_side_on    <= next_hs;
			gate.low_side_on     <= next_ls;
			bias_enable          <= next_bias;                            // R2 R3
			fault_out            <= supply_ok & (lim_fault | batt_flt);   // R14 R18
			forced_constant_freq <= next_forced;
			dither_active        <= next_dith;                            // R12
		end
	end

	// ahb-lite slave: one wait state per transfer so read data leaves a flop
	logic       pend;
	logic       a_write;
	logic [3:0] a_sel;
	wire        take   = hsel & htrans[1] & hready;
	wire [3:0]  dec    = {haddr == OFS_EVENT, haddr == OFS_STATUS,
		haddr == OFS_PERIOD, haddr == OFS_CTRL};
	wire        word   = (hsize == HSIZE_WORD);
	wire        wr_now = pend & a_write;

	wire [31:0] status_val = {14'h0, ss_level, bias_enable, s.dropout_detect, fault_out,
		dither_active, sync_clocked, forced_constant_freq, state};
	wire [31:0] rd_val = a_sel[0] ? {30'h0, ctrl} :
		a_sel[1] ? {16'h0, period} :
		a_sel[2] ? status_val :
		a_sel[3] ? {28'h0, events} : 32'h0;

	wire [EV_W-1:0] ev_set = {running & conv_rst, lim_fault, batt_flt, running & hiccup_go};
	wire [EV_W-1:0] ev_clr = (wr_now & a_sel[3]) ? hwdata[EV_W-1:0] : '0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend      <= 1'b0;
			a_write   <= 1'b0;
			a_sel     <= '0;
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
			hrdata    <= '0;
		end else if (pend) begin
			pend      <= 1'b0;
			hreadyout <= 1'b1;
			hrdata    <= a_write ? 32'h0 : rd_val;
		end else if (take) begin
			pend      <= 1'b1;
			a_write   <= hwrite;
			a_sel     <= word ? dec : 4'h0;
			hreadyout <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl   <= CTRL_RESET;
			period <= PERIOD_RESET;
			events <= '0;
		end else begin
			if (wr_now && a_sel[0]) begin
				ctrl <= hwdata[1:0];
			end
			if (wr_now && a_sel[1]) begin
				period <= hwdata[PER_W-1:0];
			end
			// a new event in the clearing cycle survives the clear
			events <= (events & ~ev_clr) | ev_set;
		end
	end

endmodule : bmf_top

`default_nettype wire

// [verif/bmf_top_checker.sv]
// concurrent checks on the ports of the converter mode and fault control
`timescale 1ns/1ps
`default_nettype none

module bmf_top_checker
	import bmf_pkg::*;
#(
	parameter int unsigned LIM_CYC = LIM_CYC_DEF
) (
	// clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// bus
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	// converter
	input wire bmf_sense_t sense_in,
	input wire bmf_gate_t  gate,
	input wire logic       bias_enable,
	input wire logic       fault_out,
	input wire logic       forced_constant_freq,
	input wire logic [9:0] ss_level
);
	// up holds off level checks until the two-flop synchroniser is refilled after reset
	logic [2:0]  up;
	logic [22:0] lim_run;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up      <= 3'h0;
			lim_run <= 23'h0;
		end else begin
			up      <= (up == 3'h7) ? up : up + 3'h1;
			lim_run <= sense_in.load_sense_over_limit ? lim_run + 23'h1 : 23'h0;
		end
	end

	sequence take_s;
		hsel && htrans[1] && hready && hreadyout;
	endsequence
	sequence en_low_s;
		!sense_in.converter_enable_in [*5];
	endsequence
	sequence peak_s;
		sense_in.peak_current_over [*4];
	endsequence

	a_bus_one_wait: assert property (
		take_s |=> !hreadyout ##1 hreadyout) else $error("bus wait not one cycle");
	a_bus_okay: assert property (
		hresp == HRESP_OKAY) else $error("bus response not okay");
	a_bias_follow: assert property (
		up == 3'h7 |-> bias_enable ==
		$past(sense_in.system_enable_in && sense_in.main_supply_above_2v7, 3))
		else $error("bias enable does not follow its inputs");
	a_off_gates: assert property (
		en_low_s |=> gate == '0) else $error("switching while disabled");
	a_uvlo_hold: assert property (
		(!sense_in.bias_above_uvlo) [*5] |=> gate == '0) else $error("switching under lockout");
	a_peak_cut: assert property (
		peak_s |=> !gate.high_side_on) else $error("high side on over peak limit");
	a_sync_forced: assert property (
		up == 3'h7 && $past(sense_in.sync_level, 3) && $past(sense_in.sync_level, 4)
		|-> forced_constant_freq) else $error("sync high without forced mode");
	a_skip_low_off: assert property (
		(!forced_constant_freq) [*3] |-> !gate.low_side_on) else $error("low side on in skip");
	a_fault_late: assert property (
		$rose(fault_out) && !sense_in.output_short_batt |-> {9'h0, lim_run} >= LIM_CYC)
		else $error("fault before limit time");
	a_fault_due: assert property (
		{9'h0, lim_run} == LIM_CYC + 6 && bias_enable && sense_in.bias_above_uvlo
		|-> fault_out) else $error("fault missing after limit time");
	a_ss_step: assert property (
		$changed(ss_level) |-> ss_level == 10'h0 || ss_level == $past(ss_level) + 10'h1)
		else $error("soft-start ramp jumped");
endmodule : bmf_top_checker

bind bmf_top bmf_top_checker #(.LIM_CYC(LIM_CYC)) u_chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.htrans(htrans),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.sense_in(sense_in),
	.gate(gate),
	.bias_enable(bias_enable),
	.fault_out(fault_out),
	.forced_constant_freq(forced_constant_freq),
	.ss_level(ss_level)
);

`default_nettype wire

// [verif/bmf_top_tb.sv]
// self-checking bench for the converter mode and fault control
`timescale 1ns/1ps
`default_nettype none

module bmf_top_tb;
	import bmf_pkg::*;
	localparam int unsigned LIM = 200;
	localparam int unsigned HIC = 300;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        bias_enable;
	logic        fault_out;
	logic        forced_constant_freq;
	logic        dither_active;
	logic        sync_clk_en = 1'b0;
	logic [9:0]  ss_level;
	bmf_gate_t   gate;
	bmf_sense_t  req = '0;
	bmf_sense_t  sense_in;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          k;
	// sync, sel hi, sel lo, d+ vih, d- vih, d+ vil, d- vil, d- float, d+ ref, load, forced
	logic [10:0] rows [12] = '{11'b00000000000, 11'b00000000011, 11'b00110000001,
		11'b00101000001, 11'b00100110000, 11'b01000001000, 11'b01000001011,
		11'b01000001101, 11'b01000000001, 11'b01100001000, 11'b11000001001,
		11'b10000000001};

	always #4 hclk = ~hclk;

	bmf_top #(.SS_CYC(2048), .LIM_CYC(LIM), .HICCUP_CYC(HIC)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense_in(sense_in),
		.gate(gate), .bias_enable(bias_enable), .fault_out(fault_out),
		.forced_constant_freq(forced_constant_freq), .dither_active(dither_active),
		.ss_level(ss_level));

	bmf_usb_side far (.hclk(hclk), .hresetn(hresetn), .req(req), .sync_clk_en(sync_clk_en),
		.gate(gate), .sense(sense_in));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic cyc(input int c);
		repeat (c) @(posedge hclk);
	endtask : cyc

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	// waits as long as the slave asks; only the watchdog ends a hang
	task automatic wait_ready();
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask : wait_ready

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : bus

	task automatic tally_and_finish();
		$display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		cyc(20000);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		cyc(5);
		check({gate, forced_constant_freq, hreadyout, fault_out, bias_enable}, 32'hc);
		@(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, OFS_CTRL, 32'h0);
		check(rd, {30'h0, CTRL_RESET});
		bus(1'b0, OFS_PERIOD, 32'h0);
		check(rd, {16'h0, PERIOD_RESET});
		bus(1'b1, OFS_PERIOD, 32'h120);
		bus(1'b0, OFS_PERIOD, 32'h0);
		check(rd, 32'h120);
		bus(1'b1, 32'h10, 32'hffff_ffff);
		bus(1'b0, 32'h10, 32'h0);
		check(rd, 32'h0);
		done("registers");
		req.system_enable_in      <= 1'b1;
		req.main_supply_above_2v7 <= 1'b1;
		req.converter_enable_in   <= 1'b1;
		cyc(40);
		check({bias_enable, gate, ss_level}, 32'h1000);
		req.bias_above_uvlo <= 1'b1;
		k = 0;
		while (ss_level !== 10'h3ff && k < 3000) begin
			@(posedge hclk);
			k++;
		end
		check({31'h0, k >= 2040 && k <= 2070}, 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0);
		check({30'h0, rd[1:0]}, {30'h0, BMF_RUN});
		done("soft start");
		bus(1'b1, OFS_CTRL, 32'h3);
		cyc(8);
		check({31'h0, dither_active}, 32'h1);
		sync_clk_en <= 1'b1;
		cyc(900);
		bus(1'b0, OFS_STATUS, 32'h0);
		check({rd[ST_SYNC_CLK], dither_active, forced_constant_freq}, 32'h5);
		sync_clk_en <= 1'b0;
		cyc(2700);
		check({dither_active, forced_constant_freq}, 32'h2);
		done("spread and sync");
		// sync-high rows sit last so no recent sync edge spoils the skip rows
		for (int i = 0; i < 12; i++) begin
			req[20:11] <= rows[i][10:1];
			cyc(6);
			check({31'h0, forced_constant_freq}, {31'h0, rows[i][0]});
		end
		req[20:11] <= 10'h0;
		cyc(2600);
		check({31'h0, forced_constant_freq}, 32'h0);
		done("mode table");
		bus(1'b1, OFS_EVENT, 32'hf);
		req.output_above_4v75 <= 1'b1;
		repeat (2) begin
			req.load_sense_over_limit <= 1'b1;
			cyc(LIM - 20);
			req.load_sense_over_limit <= 1'b0;
			cyc(2);
		end
		check({31'h0, fault_out}, 32'h0);
		req.load_sense_over_limit <= 1'b1;
		cyc(LIM + 10);
		check({31'h0, fault_out}, 32'h1);
		check({31'h0, ss_level < 10'h3ff}, 32'h1);
		bus(1'b0, OFS_EVENT, 32'h0);
		check({30'h0, rd[3:2]}, 32'h3);
		req.load_sense_over_limit <= 1'b0;
		req.output_above_4v75     <= 1'b0;
		cyc(6);
		bus(1'b1, OFS_EVENT, 32'hf);
		bus(1'b0, OFS_EVENT, 32'h0);
		check(rd, 32'h0);
		done("load limit");
		req.output_short_batt <= 1'b1;
		cyc(8);
		check({30'h0, gate}, 32'h0);
		cyc(985);
		check({31'h0, fault_out}, 32'h0);
		cyc(15);
		check({31'h0, fault_out}, 32'h1);
		req.output_short_batt <= 1'b0;
		cyc(8);
		bus(1'b1, OFS_EVENT, 32'hf);
		req.peak_current_over <= 1'b1;
		req.output_below_2v0  <= 1'b1;
		cyc(1500);
		bus(1'b0, OFS_EVENT, 32'h0);
		check({31'h0, rd[EV_HICCUP]}, 32'h1);
		req.peak_current_over <= 1'b0;
		req.output_below_2v0  <= 1'b0;
		cyc(320);
		req.output_short_gnd <= 1'b1;
		cyc(6);
		req.output_short_gnd <= 1'b0;
		bus(1'b0, OFS_STATUS, 32'h0);
		check({30'h0, rd[1:0]}, {30'h0, BMF_HICCUP});
		cyc(HIC);
		bus(1'b0, OFS_STATUS, 32'h0);
		check({30'h0, rd[1:0]}, {30'h0, BMF_SOFT});
		req.dropout_detect <= 1'b1;
		cyc(6);
		bus(1'b0, OFS_STATUS, 32'h0);
		check({31'h0, rd[ST_DROPOUT]}, 32'h1);
		done("faults");
		hresetn <= 1'b0;
		cyc(2);
		check({ss_level, forced_constant_freq}, 32'h1);
		hresetn                <= 1'b1;
		req.system_enable_in <= 1'b0;
		cyc(8);
		check({bias_enable, gate}, 32'h0);
		done("reset and shutdown");
		tally_and_finish();
	end
endmodule : bmf_top_tb

`default_nettype wire

// [verif/bmf_usb_side.sv]
// model of the usb controller, sync source and portable load on the far side
`timescale 1ns/1ps
`default_nettype none

module bmf_usb_side
	import bmf_pkg::*;
#(
	parameter int unsigned SYNC_HALF = 142,
	parameter int unsigned LAG       = 3
) (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// levels commanded by the bench
	input  wire bmf_sense_t req,
	input  wire logic       sync_clk_en,
	// switch drives
	input  wire bmf_gate_t  gate,
	// comparator levels to the converter
	output var  bmf_sense_t sense
);
	logic [7:0] div;
	logic       sclk;
	logic [3:0] fill;

	// even duty at the resistor-set rate, well under the top sync rate; idle low when off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div  <= 8'h0;
			sclk <= 1'b0;
		end else if (!sync_clk_en || div == 8'(SYNC_HALF - 1)) begin
			div  <= 8'h0;
			sclk <= sync_clk_en & ~sclk;
		end else begin
			div <= div + 8'h1;
		end
	end

	// crude output charge: rises while the high side is on, drains otherwise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			fill <= 4'h0;
		else if (gate.high_side_on)
			fill <= (fill == 4'hf) ? fill : fill + 4'h1;
		else
			fill <= (fill == 4'h0) ? fill : fill - 4'h1;
	end

	always_comb begin
		sense                     = req;
		sense.sync_level          = sync_clk_en ? sclk : req.sync_level;
		sense.output_below_target = req.output_below_target | (fill < 4'(LAG));
		sense.skip_peak_reached   = req.skip_peak_reached | (fill >= 4'(2 * LAG));
		sense.feedback_above_reg  = req.feedback_above_reg | (fill >= 4'(2 * LAG));
	end
endmodule : bmf_usb_side

`default_nettype wire
